// >>> src/prc_regs.vh
`ifndef PRC_REGS_VH
`define PRC_REGS_VH
`define PRC_ADDR_ACCESS_CTRL 8'h08
`define PRC_ADDR_SAMPLE_DATA 8'h09
`define PRC_ADDR_RX_OUT_CFG 8'h0a
`define PRC_ADDR_RX_EQ_CFG 8'h0b
`define PRC_ADDR_TX_SCALE 8'h07
`define PRC_RST_ACCESS_CTRL 8'h00
`define PRC_RST_SAMPLE_DATA 7'h00
`define PRC_RST_RX_OUT_CFG 5'h00
`define PRC_RST_EQUALIZER_ENABLE 1'h0
`define PRC_RST_LOS_SEL 5'h15
`define PRC_RST_SCALE 6'h21
`define PRC_BIT_TRIGGER 7
`define PRC_BIT_DIR 6
`define PRC_BIT_RX_OFF 4
`define PRC_BIT_RX_INV 3
`define PRC_BIT_CLK_EDGE 2
`define PRC_BIT_EQUALIZER_ENABLE 6
`define PRC_UI_MSB 5
`define PRC_UI_LSB 4
`define PRC_SAMP_MSB 3
`define PRC_SAMP_LSB 0
`define PRC_RX_CFG_MSB 4
`define PRC_LOS_MSB 4
`define PRC_SCALE_MSB 5
`define PRC_LOS_MAX 5'h0a
`define PRC_MODE_HDB3 2'h0
`define PRC_MODE_AMI 2'h1
`define PRC_MODE_DUAL 2'h2
`define PRC_MODE_SLICER 2'h3
`endif

// >>> src/prc_config_regs.v
// Functional notes
// [R1] writing trigger one starts one indirect RAM access
// [R2] direction clear writes RAM, set reads
// [R3] two-bit unit interval index selects interval
// [R4] four-bit sample index selects sample
// [R5] indirect write stores data register amplitude
// [R6] indirect read returns amplitude into data register
// [R7] power-down bit drives receiver off, resets up
// [R8] polarity bit inverts rail outputs when set
// [R9] edge bit picks falling edge, ignored slicer
// [R10] modes 00/01 give decoded single-rail output
// [R11] modes 10/11 select dual-rail or raw slicer
// [R12] equalizer enable also arms loss thresholds
// [R13] loss threshold codes above 01010 are reserved
// [R14] six-bit scale factor for programmed pulses
// [R15] trigger self-clears when the access finishes
`timescale 1ns/1ps
`default_nettype none
`include "prc_regs.vh"
module prc_config_regs #(
    parameter UI_COUNT = 4,
    parameter SAMPLE_COUNT = 16,
    parameter AMP_W = 7
) (
    // clock, reset, enable
    input wire core_clk,
    input wire nrst,
    input wire clkEn,
    // host register port
    input wire [7:0] regAddr,
    input wire regWrEn,
    input wire [7:0] regWrData,
    input wire regRdEn,
    output reg [7:0] regRdData,
    // waveform generator read port
    input wire [5:0] genAddr,
    output reg [AMP_W-1:0] genAmplitude,
    output wire [5:0] pulse_amplitude_scale,
    // receive datapath controls
    output wire rxPowerDown,
    output wire rx_polarity_select,
    output wire rxFallingEdge,
    output wire [1:0] rx_decode_mode,
    output wire rxSingleRail,
    output wire rxSlicerBypass,
    output wire equalizer_enable,
    output wire losProgEnable,
    output wire [4:0] signal_loss_threshold_select,
    output wire losSelectValid
);
    localparam DEPTH = UI_COUNT * SAMPLE_COUNT;

    reg [AMP_W-1:0] ram [0:DEPTH-1];
    reg trigger_r;
    reg dir_r;
    reg [1:0] uiIdx_r;
    reg [3:0] sampIdx_r;
    reg [AMP_W-1:0] amp_r;
    reg [4:0] rxOut_r;
    reg eqOn_r;
    reg [4:0] losSel_r;
    reg [5:0] scale_r;
    wire [5:0] ramIdx;
    wire ctrlWr;
    wire dataWr;
    wire rxOutWr;
    wire eqWr;
    wire scaleWr;
    wire ramWrStb;
    wire [AMP_W-1:0] ramRdWord;

    // next values, settled before each enabled edge
    reg trigger_nxt;
    reg dir_nxt;
    reg [1:0] uiIdx_nxt;
    reg [3:0] sampIdx_nxt;
    reg [AMP_W-1:0] amp_nxt;
    reg [4:0] rxOut_nxt;
    reg eqOn_nxt;
    reg [4:0] losSel_nxt;
    reg [5:0] scale_nxt;
    reg [7:0] rdMux;

    // leftmost interval and sample sit at index zero
    assign ramIdx = {uiIdx_r, sampIdx_r}; // [R3] [R4]
    assign ctrlWr = regWrEn && (regAddr == `PRC_ADDR_ACCESS_CTRL);
    assign dataWr = regWrEn && (regAddr == `PRC_ADDR_SAMPLE_DATA);
    assign rxOutWr = regWrEn && (regAddr == `PRC_ADDR_RX_OUT_CFG);
    assign eqWr = regWrEn && (regAddr == `PRC_ADDR_RX_EQ_CFG);
    assign scaleWr = regWrEn && (regAddr == `PRC_ADDR_TX_SCALE);
    // the ram only writes in the completion cycle of a write access
    assign ramWrStb = trigger_r && !dir_r; // [R2] [R5]
    assign ramRdWord = ram[ramIdx];

    // access control: a busy trigger refuses new control writes for one cycle
    always @* begin
        trigger_nxt = trigger_r;
        dir_nxt = dir_r;
        uiIdx_nxt = uiIdx_r;
        sampIdx_nxt = sampIdx_r;
        if (trigger_r) begin
            // access runs in the cycle after the trigger write
            trigger_nxt = 1'b0; // [R15]
        end else if (ctrlWr) begin
            // control held during an access so the address stays stable
            trigger_nxt = regWrData[`PRC_BIT_TRIGGER]; // [R1]
            dir_nxt = regWrData[`PRC_BIT_DIR];
            uiIdx_nxt = regWrData[`PRC_UI_MSB:`PRC_UI_LSB];
            sampIdx_nxt = regWrData[`PRC_SAMP_MSB:`PRC_SAMP_LSB];
        end
    end

    // sample data: a read result wins over a host write in the same cycle
    always @* begin
        amp_nxt = amp_r;
        if (trigger_r && dir_r) begin
            amp_nxt = ramRdWord; // [R2] [R6]
        end else if (dataWr) begin
            amp_nxt = regWrData[AMP_W-1:0];
        end
    end

    // receive and scale configuration, stored as written
    always @* begin
        rxOut_nxt = rxOut_r;
        eqOn_nxt = eqOn_r;
        losSel_nxt = losSel_r;
        scale_nxt = scale_r;
        if (rxOutWr) begin
            rxOut_nxt = regWrData[`PRC_RX_CFG_MSB:0]; // [R7]
        end
        if (eqWr) begin
            // reserved loss codes are kept so software reads back what it wrote
            eqOn_nxt = regWrData[`PRC_BIT_EQUALIZER_ENABLE];
            losSel_nxt = regWrData[`PRC_LOS_MSB:0];
        end
        if (scaleWr) begin
            scale_nxt = regWrData[`PRC_SCALE_MSB:0]; // [R14]
        end
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            trigger_r <= 1'b0;
            dir_r <= 1'b0;
            uiIdx_r <= 2'h0;
            sampIdx_r <= 4'h0;
            amp_r <= `PRC_RST_SAMPLE_DATA;
            rxOut_r <= `PRC_RST_RX_OUT_CFG;
            eqOn_r <= `PRC_RST_EQUALIZER_ENABLE;
            losSel_r <= `PRC_RST_LOS_SEL;
            scale_r <= `PRC_RST_SCALE;
        end else if (clkEn) begin
            trigger_r <= trigger_nxt;
            dir_r <= dir_nxt;
            uiIdx_r <= uiIdx_nxt;
            sampIdx_r <= sampIdx_nxt;
            amp_r <= amp_nxt;
            rxOut_r <= rxOut_nxt;
            eqOn_r <= eqOn_nxt;
            losSel_r <= losSel_nxt;
            scale_r <= scale_nxt;
        end
    end

    // ram has no reset; contents are undefined until software loads them
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi = gi + 1) begin : gRam
            // each word decodes its own index, so at most one word is enabled
            localparam [5:0] ENTRY = gi;
            wire wrHit;
            assign wrHit = ramWrStb && (ramIdx == ENTRY); // [R3] [R4]
            always @(posedge core_clk) begin
                if (clkEn && wrHit) begin
                    ram[gi] <= amp_r; // [R5]
                end
            end
        end
    endgenerate

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            genAmplitude <= {AMP_W{1'b0}};
        end else if (clkEn) begin
            genAmplitude <= ram[genAddr];
        end
    end

    // read data is a flop so the host sees a stable byte until the next read
    always @* begin
        case (regAddr)
            `PRC_ADDR_ACCESS_CTRL: rdMux = {trigger_r, dir_r, uiIdx_r, sampIdx_r};
            `PRC_ADDR_SAMPLE_DATA: rdMux = {1'b0, amp_r};
            `PRC_ADDR_RX_OUT_CFG: rdMux = {3'h0, rxOut_r};
            `PRC_ADDR_RX_EQ_CFG: rdMux = {1'b0, eqOn_r, 1'b0, losSel_r};
            `PRC_ADDR_TX_SCALE: rdMux = {2'h0, scale_r};
            // reserved bits and unmapped addresses read as zero
            default: rdMux = 8'h00;
        endcase
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            regRdData <= 8'h00;
        end else if (clkEn && regRdEn) begin
            regRdData <= rdMux;
        end
    end

    // receive controls are plain decodes of the stored bits
    assign rxPowerDown = rxOut_r[`PRC_BIT_RX_OFF]; // [R7]
    assign rx_polarity_select = rxOut_r[`PRC_BIT_RX_INV]; // [R8]
    assign rx_decode_mode = rxOut_r[1:0]; // [R10] [R11]
    assign rxSlicerBypass = (rxOut_r[1:0] == `PRC_MODE_SLICER); // [R11]
    assign rxSingleRail = (rxOut_r[1:0] == `PRC_MODE_HDB3) || (rxOut_r[1:0] == `PRC_MODE_AMI); // [R10]
    // edge choice is meaningless once clock recovery is bypassed
    assign rxFallingEdge = rxOut_r[`PRC_BIT_CLK_EDGE] && !rxSlicerBypass; // [R9]
    assign equalizer_enable = eqOn_r; // [R12]
    assign losProgEnable = eqOn_r && losSelectValid; // [R12]
    assign signal_loss_threshold_select = losSel_r;
    assign losSelectValid = (losSel_r <= `PRC_LOS_MAX); // [R13]
    assign pulse_amplitude_scale = scale_r;
endmodule // prc_config_regs
`default_nettype wire

// >>> bench/prc_config_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module prc_config_regs_chk (
    input wire logic core_clk, nrst, clkEn, regWrEn, regRdEn,
    input wire logic [7:0] regAddr, regWrData, regRdData,
    input wire logic rxPowerDown, rx_polarity_select, rxFallingEdge, rxSingleRail,
    input wire logic rxSlicerBypass, equalizer_enable, losProgEnable, losSelectValid,
    input wire logic [1:0] rx_decode_mode,
    input wire logic [4:0] signal_loss_threshold_select
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    wire logic wA = regWrEn && clkEn && regAddr == 8'h0a;
    wire logic wB = regWrEn && clkEn && regAddr == 8'h0b;
    chk_rx_cfg: assert property (wA |=>
        {rxPowerDown, rx_polarity_select} == $past(regWrData[4:3])
        && rx_decode_mode == $past(regWrData[1:0])) else $error("rx config not taken");
    chk_edge_sel: assert property (wA |=> rxFallingEdge ==
        ($past(regWrData[2]) && $past(regWrData[1:0]) != 2'h3)) else $error("edge select wrong");
    chk_mode_single: assert property (rxSingleRail == !rx_decode_mode[1])
        else $error("single rail decode wrong");
    chk_mode_slicer: assert property (rxSlicerBypass == (rx_decode_mode == 2'h3))
        else $error("slicer decode wrong");
    chk_los_cfg: assert property (wB |=>
        {equalizer_enable, signal_loss_threshold_select} ==
        {$past(regWrData[6]), $past(regWrData[4:0])}) else $error("los config not taken");
    chk_los_valid: assert property (
        losSelectValid == (signal_loss_threshold_select <= 5'h0a))
        else $error("reserved loss code accepted");
    chk_los_arm: assert property (losProgEnable == (equalizer_enable && losSelectValid))
        else $error("loss thresholds armed wrongly");
    chk_unmapped_rd: assert property (regRdEn && clkEn && regAddr == 8'h20 |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
endmodule // prc_config_regs_chk
bind prc_config_regs prc_config_regs_chk u_chk (.core_clk, .nrst, .clkEn, .regWrEn, .regRdEn,
    .regAddr, .regWrData, .regRdData, .rxPowerDown, .rx_polarity_select, .rxFallingEdge,
    .rxSingleRail, .rxSlicerBypass, .equalizer_enable, .losProgEnable, .losSelectValid,
    .rx_decode_mode, .signal_loss_threshold_select);
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic core_clk = 0, nrst = 0, clkEn = 1, regWrEn = 0, regRdEn = 0;
    logic [7:0] regAddr = 0, regWrData = 0;
    logic [5:0] genAddr = 0;
    wire [7:0] regRdData;
    wire [6:0] ampOut;
    wire [5:0] scaleOut;
    wire [4:0] losSel;
    wire [1:0] mode;
    wire rxOff, rxInv, rxFall, rail1, slicer, eqOn, losArm, losOk;
    integer n_mismatch = 0, cmp_count = 0, cyc = 0, i;
    prc_config_regs dut (.core_clk(core_clk), .nrst(nrst), .clkEn(clkEn), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .genAddr(genAddr), .genAmplitude(ampOut), .pulse_amplitude_scale(scaleOut),
        .rxPowerDown(rxOff), .rx_polarity_select(rxInv), .rxFallingEdge(rxFall),
        .rx_decode_mode(mode), .rxSingleRail(rail1), .rxSlicerBypass(slicer),
        .equalizer_enable(eqOn), .losProgEnable(losArm),
        .signal_loss_threshold_select(losSel), .losSelectValid(losOk));
    initial forever #5 core_clk = ~core_clk;
    task give_verdict;
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // hang guard, the whole sequence needs well under a thousand cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            give_verdict;
        end
    end
    task chk(input string nm, input logic [7:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s exp %h got %h", nm, exp, got);
        end
    endtask
    task wr(input logic [7:0] a, d);
        @(negedge core_clk) {regAddr, regWrData, regWrEn} = {a, d, 1'b1};
        @(negedge core_clk) regWrEn = 0;
    endtask
    task rd(input logic [7:0] a, exp, input string nm);
        @(negedge core_clk) {regAddr, regRdEn} = {a, 1'b1};
        @(negedge core_clk) regRdEn = 0;
        chk(nm, exp, regRdData);
    endtask
    initial begin
        repeat (3) @(negedge core_clk);
        nrst = 1;
        rd(8'h08, 8'h00, "ctrl");
        rd(8'h0a, 8'h00, "rxcfg");
        rd(8'h0b, 8'h15, "eqcfg");
        rd(8'h07, 8'h21, "scale");
        rd(8'h20, 8'h00, "unmapped");
        // indices 0, 21, 42, 63 reach every interval and both sample ends
        for (i = 0; i < 64; i += 21) begin
            wr(8'h09, 8'h2a ^ i[7:0]);
            wr(8'h08, 8'h80 | i[7:0]);
            rd(8'h08, i[7:0], "ctrl");
        end
        for (i = 0; i < 64; i += 21) begin
            wr(8'h09, 8'h00);
            wr(8'h08, 8'hc0 | i[7:0]);
            rd(8'h08, 8'h40 | i[7:0], "ctrl");
            rd(8'h09, 8'h2a ^ i[7:0], "data");
            genAddr = i[5:0];
            @(negedge core_clk) chk("gen", 8'h2a ^ i[7:0], {1'b0, ampOut});
        end
        for (i = 0; i < 4; i++) begin
            wr(8'h0a, 8'h1c | i[7:0]);
            chk("rx", {3'h7, i != 3, i[1:0], !i[1], i == 3},
                {rxOff, rxInv, 1'b1, rxFall, mode, rail1, slicer});
        end
        // powered up, active high, rising edge, dual rail
        wr(8'h0a, 8'h02);
        chk("rx", 8'h28, {rxOff, rxInv, 1'b1, rxFall, mode, rail1, slicer});
        wr(8'h0b, 8'h4a);
        chk("los", 8'h07, {5'h0, eqOn, losArm, losOk});
        wr(8'h0b, 8'h4b);
        chk("los", 8'h04, {5'h0, eqOn, losArm, losOk});
        chk("lossel", 8'h0b, {3'h0, losSel});
        wr(8'h0b, 8'h0a);
        chk("los", 8'h01, {5'h0, eqOn, losArm, losOk});
        wr(8'h07, 8'hff);
        chk("scale", 8'h3f, {2'h0, scaleOut});
        // a frozen clock enable must not let the write land
        clkEn = 0;
        wr(8'h0a, 8'h00);
        clkEn = 1;
        rd(8'h0a, 8'h02, "rxcfg");
        give_verdict;
    end
endmodule // testbench
`default_nettype wire
